// ### logic/selim_pkg.sv
package selim_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned POS_W   = 32;
  localparam int unsigned LIM_W   = 16;
  localparam int unsigned DLY_W   = 16;
  localparam int unsigned ADDR_W  = 8;

  // ==========================================================================
  // Servo cycle
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned SERVO_US      = 120;
  localparam int unsigned SERVO_CYCLES  = (CLK_HZ / 1_000_000) * SERVO_US;
  localparam int unsigned TICK_W        = 13;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_LIMITS  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_DELAY   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_ISW     = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IOS     = 8'h10;
  localparam logic [ADDR_W-1:0] REG_PSW     = 8'h14;
  localparam logic [ADDR_W-1:0] REG_MASK    = 8'h18;
  localparam logic [ADDR_W-1:0] REG_TARGET  = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_STATE   = 8'h20;
  localparam logic [ADDR_W-1:0] REG_KILL    = 8'h24;

  // ==========================================================================
  // Field positions
  localparam int unsigned BIT_MOVE_ERR  = 0;
  localparam int unsigned BIT_HOLD_ERR  = 1;
  localparam int unsigned BIT_DRAG_EN   = 0;
  localparam int unsigned BIT_HOLDING   = 0;
  localparam int unsigned BIT_SETTLING  = 1;
  localparam int unsigned HOLD_LIM_LSB  = 16;
  localparam int unsigned STAT_W        = 2;

  // ==========================================================================
  // Reset values
  localparam logic [LIM_W-1:0]  RST_MOVE_LIM = 16'h0100;
  localparam logic [LIM_W-1:0]  RST_HOLD_LIM = 16'h0040;
  localparam logic [DLY_W-1:0]  RST_DELAY    = 16'h000a;

  typedef enum logic [1:0] {
    SELIM_MOVING,
    SELIM_SETTLING,
    SELIM_HOLDING
  } selim_mode_e;

endpackage

// ### logic/selim_core.sv
// How it works
// - Moving torque is selected while the trajectory generator is active.
// - Position error equals actual position minus target position.
// - Error magnitude above moving limit sets moving flag in all three words.
// - Every status word has a moving bit and a separate holding bit.
// - Generator going idle with target steady starts the settle timer.
// - Before timer expiry, moving torque and moving limit remain in use.
// - After expiry, holding torque and holding limit; holding flag reported.
// - Configuration sets moving limit, holding limit, settle delay, drag enable.
// - Drag mode clamps target to within the active limit of actual.
// - Drag mode still sets internal flags, which still feed shutdown.
// - Internal flags feed shutdown; I/O and polling flags alert host.
// - Holding with drag: target follows the pushed shaft.
// - Basic moves run fixed duration; clamp may leave them short.
// - Profile moves recompute each 120 us servo cycle to reach destination.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module selim_core (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic [selim_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [31:0]                    pwdata,
  input  wire logic [3:0]                     pstrb,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           traj_active,
  input  wire logic [selim_pkg::POS_W-1:0]    traj_target,
  input  wire logic [selim_pkg::POS_W-1:0]    actual_pos,
  output logic      [selim_pkg::POS_W-1:0]    control_target,
  output logic                                holding_torque,
  output logic                                servo_tick,
  output logic                                kill_request,
  output logic                                irq
);
  import selim_pkg::*;

  // ==========================================================================
  // Servo cycle tick
  logic [TICK_W-1:0] tick_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
    end else if (tick_cnt_q == TICK_W'(SERVO_CYCLES - 1)) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end
  assign servo_tick = (tick_cnt_q == TICK_W'(SERVO_CYCLES - 1));

  // ==========================================================================
  // Configuration registers
  logic [LIM_W-1:0]  move_lim_q;
  logic [LIM_W-1:0]  hold_lim_q;
  logic [DLY_W-1:0]  delay_q;
  logic              drag_en_q;
  logic [STAT_W-1:0] mask_q;
  logic [STAT_W-1:0] kill_mask_q;
  logic              wr_en;
  assign wr_en = psel && penable && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      move_lim_q  <= RST_MOVE_LIM;
      hold_lim_q  <= RST_HOLD_LIM;
      delay_q     <= RST_DELAY;
      drag_en_q   <= 1'b0;
      mask_q      <= '0;
      kill_mask_q <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        REG_CTRL: begin
          drag_en_q <= pwdata[BIT_DRAG_EN];
        end
        REG_LIMITS: begin
          move_lim_q <= pwdata[LIM_W-1:0];
          hold_lim_q <= pwdata[HOLD_LIM_LSB +: LIM_W];
        end
        REG_DELAY: begin
          delay_q <= pwdata[DLY_W-1:0];
        end
        REG_MASK: begin
          mask_q <= pwdata[STAT_W-1:0];
        end
        REG_KILL: begin
          kill_mask_q <= pwdata[STAT_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Mode and settle timer
  selim_mode_e      mode_q;
  logic [DLY_W-1:0] settle_q;
  logic [POS_W-1:0] last_traj_q;
  logic             target_still;
  assign target_still = (traj_target == last_traj_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_traj_q <= '0;
    end else if (servo_tick) begin
      last_traj_q <= traj_target;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q   <= SELIM_HOLDING;
      settle_q <= '0;
    end else if (servo_tick) begin
      if (traj_active) begin
        mode_q <= SELIM_MOVING;
      end else begin
        unique case (mode_q)
          SELIM_MOVING: begin
            if (target_still) begin
              mode_q   <= SELIM_SETTLING;
              settle_q <= delay_q;
            end
          end
          SELIM_SETTLING: begin
            if (settle_q == '0) begin
              mode_q <= SELIM_HOLDING;
            end else begin
              settle_q <= settle_q - 1'b1;
            end
          end
          SELIM_HOLDING: begin
          end
        endcase
      end
    end
  end
  // Generator activity overrides the mode at once
  assign holding_torque = (mode_q == SELIM_HOLDING) && !traj_active;

  // ==========================================================================
  // Error computation and drag clamp
  logic [POS_W-1:0] err;
  logic [POS_W-1:0] err_abs;
  logic [POS_W-1:0] lim_ext;
  logic             err_over;
  logic [POS_W-1:0] clamped;
  assign err      = actual_pos - traj_target;
  assign err_abs  = err[POS_W-1] ? (~err + 1'b1) : err;
  assign lim_ext  = holding_torque ? POS_W'(hold_lim_q) : POS_W'(move_lim_q);
  assign err_over = (err_abs > lim_ext);
  // Target pulled toward actual; holding target follows the shaft
  assign clamped  = err[POS_W-1] ? (actual_pos + lim_ext) : (actual_pos - lim_ext);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_target <= '0;
    end else if (servo_tick) begin
      control_target <= (drag_en_q && err_over) ? clamped : traj_target;
    end
  end

  // ==========================================================================
  // Status words
  logic [STAT_W-1:0] isw_q;
  logic [STAT_W-1:0] ios_q;
  logic [STAT_W-1:0] psw_q;
  logic [STAT_W-1:0] ev;
  logic [STAT_W-1:0] clr_isw;
  logic [STAT_W-1:0] clr_ios;
  logic [STAT_W-1:0] clr_psw;
  always_comb begin
    ev = '0;
    if (servo_tick && err_over) begin
      ev[BIT_MOVE_ERR] = !holding_torque;
      ev[BIT_HOLD_ERR] = holding_torque;
    end
  end
  assign clr_isw = (wr_en && paddr == REG_ISW) ? pwdata[STAT_W-1:0] : '0;
  assign clr_ios = (wr_en && paddr == REG_IOS) ? pwdata[STAT_W-1:0] : '0;
  assign clr_psw = (wr_en && paddr == REG_PSW) ? pwdata[STAT_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isw_q <= '0;
      ios_q <= '0;
      psw_q <= '0;
    end else begin
      // Set wins over a simultaneous clear
      isw_q <= (isw_q & ~clr_isw) | ev;
      ios_q <= (ios_q & ~clr_ios) | ev;
      psw_q <= (psw_q & ~clr_psw) | ev;
    end
  end
  assign kill_request = |(isw_q & kill_mask_q);
  assign irq          = |((ios_q | psw_q) & mask_q);

  // ==========================================================================
  // APB read path
  assign pready  = 1'b1;
  logic known;
  always_comb begin
    known = 1'b1;
    unique case (paddr)
      REG_CTRL, REG_LIMITS, REG_DELAY, REG_ISW, REG_IOS, REG_PSW,
      REG_MASK, REG_TARGET, REG_STATE, REG_KILL: known = 1'b1;
      default: known = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !known;

  logic [31:0] rd_d;
  always_comb begin
    rd_d = '0;
    unique case (paddr)
      REG_CTRL:   rd_d[BIT_DRAG_EN] = drag_en_q;
      REG_LIMITS: rd_d = {hold_lim_q, move_lim_q};
      REG_DELAY:  rd_d[DLY_W-1:0] = delay_q;
      REG_ISW:    rd_d[STAT_W-1:0] = isw_q;
      REG_IOS:    rd_d[STAT_W-1:0] = ios_q;
      REG_PSW:    rd_d[STAT_W-1:0] = psw_q;
      REG_MASK:   rd_d[STAT_W-1:0] = mask_q;
      REG_TARGET: rd_d = control_target;
      REG_STATE: begin
        rd_d[BIT_HOLDING]  = holding_torque;
        rd_d[BIT_SETTLING] = (mode_q == SELIM_SETTLING);
      end
      REG_KILL:   rd_d[STAT_W-1:0] = kill_mask_q;
      default:    rd_d = '0;
    endcase
  end

  // Read word captured in the setup phase, held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_d;
    end
  end

  // ==========================================================================
  // Assertions
  property p_tick_period;
    @(posedge pclk) disable iff (!presetn)
      servo_tick |=> !servo_tick [*8];
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("servo tick too frequent");

  property p_active_moving;
    @(posedge pclk) disable iff (!presetn)
      (servo_tick && traj_active) |=> !holding_torque;
  endproperty
  a_active_moving: assert property (p_active_moving) else $error("holding while active");

  property p_move_flag;
    @(posedge pclk) disable iff (!presetn)
      (servo_tick && err_over && !holding_torque) |=> (isw_q[BIT_MOVE_ERR] && ios_q[BIT_MOVE_ERR]
        && psw_q[BIT_MOVE_ERR]);
  endproperty
  a_move_flag: assert property (p_move_flag) else $error("moving error not flagged");

  property p_hold_flag;
    @(posedge pclk) disable iff (!presetn)
      (servo_tick && err_over && holding_torque) |=> (isw_q[BIT_HOLD_ERR] && ios_q[BIT_HOLD_ERR]
        && psw_q[BIT_HOLD_ERR]);
  endproperty
  a_hold_flag: assert property (p_hold_flag) else $error("holding error not flagged");

  property p_settle_start;
    @(posedge pclk) disable iff (!presetn)
      (servo_tick && !traj_active && mode_q == SELIM_MOVING && target_still)
        |=> (mode_q == SELIM_SETTLING && settle_q == delay_q);
  endproperty
  a_settle_start: assert property (p_settle_start) else $error("settle timer not started");

  property p_settle_moving;
    @(posedge pclk) disable iff (!presetn)
      (servo_tick && mode_q == SELIM_SETTLING && err_over) |=> isw_q[BIT_MOVE_ERR];
  endproperty
  a_settle_moving: assert property (p_settle_moving) else $error("limit wrong settling");

  property p_drag_clamp;
    @(posedge pclk) disable iff (!presetn)
      (servo_tick && drag_en_q && err_over) |=> (control_target == $past(clamped));
  endproperty
  a_drag_clamp: assert property (p_drag_clamp) else $error("drag clamp missing");

  property p_no_drag;
    @(posedge pclk) disable iff (!presetn)
      (servo_tick && !drag_en_q) |=> (control_target == $past(traj_target));
  endproperty
  a_no_drag: assert property (p_no_drag) else $error("target altered without drag");

  property p_kill;
    @(posedge pclk) disable iff (!presetn)
      (servo_tick && err_over && !holding_torque && kill_mask_q[BIT_MOVE_ERR] && !wr_en)
        |=> kill_request;
  endproperty
  a_kill: assert property (p_kill) else $error("kill not raised");

  property p_hold_after;
    @(posedge pclk) disable iff (!presetn)
      (servo_tick && !traj_active && mode_q == SELIM_SETTLING && settle_q == '0)
        |=> (mode_q == SELIM_HOLDING);
  endproperty
  a_hold_after: assert property (p_hold_after) else $error("holding not entered");

  property p_settle_count;
    @(posedge pclk) disable iff (!presetn)
      (servo_tick && !traj_active && mode_q == SELIM_SETTLING && settle_q != '0)
        |=> (mode_q == SELIM_SETTLING && settle_q == $past(settle_q) - 1'b1);
  endproperty
  a_settle_count: assert property (p_settle_count) else $error("settle count wrong");

  property p_drag_bound;
    @(posedge pclk) disable iff (!presetn)
      (servo_tick && drag_en_q && err_over) |=> (($past(err[POS_W-1]) ?
        (control_target - $past(actual_pos)) : ($past(actual_pos) - control_target))
        == $past(lim_ext));
  endproperty
  a_drag_bound: assert property (p_drag_bound) else $error("drag distance wrong");

  property p_no_clamp;
    @(posedge pclk) disable iff (!presetn)
      (servo_tick && drag_en_q && !err_over) |=> (control_target == $past(traj_target));
  endproperty
  a_no_clamp: assert property (p_no_clamp) else $error("target clamped within limit");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      (clr_isw[BIT_MOVE_ERR] && !ev[BIT_MOVE_ERR]) |=> !isw_q[BIT_MOVE_ERR];
  endproperty
  a_clear: assert property (p_clear) else $error("moving flag not cleared");

  c_settle: cover property (@(posedge pclk) disable iff (!presetn)
    mode_q == SELIM_SETTLING ##1 mode_q == SELIM_HOLDING);
  c_drag: cover property (@(posedge pclk) disable iff (!presetn)
    servo_tick && drag_en_q && err_over);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_hold_err: cover property (@(posedge pclk) disable iff (!presetn)
    servo_tick && err_over && holding_torque);
  c_kill: cover property (@(posedge pclk) disable iff (!presetn) $rose(kill_request));
endmodule

// ### tb/selim_feed.sv
`timescale 1ns/1ps
// ==========================================
// Generator and encoder model
module selim_feed (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic        act_req,
  input  wire logic [31:0] tgt_req,
  input  wire logic [31:0] pos_req,
  output logic             traj_active,
  output logic [31:0]      traj_target,
  output logic [31:0]      actual_pos
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      traj_active <= 1'b0;
      traj_target <= 32'h0;
      actual_pos  <= 32'h0;
    end else if (load) begin
      traj_active <= act_req;
      traj_target <= tgt_req;
      actual_pos  <= pos_req;
    end
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import selim_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic        load = 1'b0;
  logic        act_req = 1'b0;
  logic [31:0] tgt_req = 32'h0;
  logic [31:0] pos_req = 32'h0;
  logic [31:0] prdata, traj_target, actual_pos, control_target, rd, t, last, gap, cyc = 0;
  logic        pready, pslverr, traj_active, holding_torque, servo_tick, kill_request, irq, er;
  int          miscompares = 0;
  int          compares = 0;

  always #10 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 32'h1;

  selim_core selim_core_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .traj_active(traj_active), .traj_target(traj_target),
    .actual_pos(actual_pos), .control_target(control_target), .holding_torque(holding_torque),
    .servo_tick(servo_tick), .kill_request(kill_request), .irq(irq));
  selim_feed selim_feed_inst (.pclk(pclk), .presetn(presetn), .load(load), .act_req(act_req),
    .tgt_req(tgt_req), .pos_req(pos_req), .traj_active(traj_active),
    .traj_target(traj_target), .actual_pos(actual_pos));

  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) begin
      miscompares++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  task automatic feed(input logic a, input logic [31:0] tg, input logic [31:0] p);
    act_req <= a;
    tgt_req <= tg;
    pos_req <= p;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
  endtask
  task automatic tick();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (servo_tick !== 1'b1 && n < 7000);
    if (n >= 7000) begin
      miscompares++;
      end_of_test();
    end
    gap = cyc - last;
    last = cyc;
    @(posedge pclk);
  endtask
  // Expected target after the drag clamp
  function automatic logic [31:0] exp_tgt(input logic drag, input logic [31:0] act, tg,
                                          input logic [31:0] lim);
    logic signed [31:0] e;
    e = act - tg;
    if (!drag || (e <= $signed(lim) && e >= -$signed(lim))) return tg;
    return (e < 0) ? act + lim : act - lim;
  endfunction

  // ==========================================
  // Main sequence
  initial begin
    rd = $urandom(32'h3f936930);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("hold after reset", holding_torque, 32'h1);
    rdchk("limits", REG_LIMITS, {RST_HOLD_LIM, RST_MOVE_LIM});
    rdchk("delay", REG_DELAY, {16'h0, RST_DELAY});
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped err", er, 32'h1);
    apb(1'b1, REG_DELAY, 32'h0);
    apb(1'b1, REG_MASK, 32'h3);
    apb(1'b1, REG_KILL, 32'h3);
    rdchk("delay wr", REG_DELAY, 32'h0);
    rdchk("irq mask", REG_MASK, 32'h3);
    rdchk("kill mask", REG_KILL, 32'h3);
    feed(1'b1, 32'd1000, 32'd1257);
    tick();
    chk("move torque", holding_torque, 32'h0);
    chk("target", control_target, exp_tgt(1'b0, 32'd1257, 32'd1000, 32'h100));
    for (int a = 0; a < 3; a++) rdchk("move flag", REG_ISW + 8'(4 * a), 32'h1);
    chk("kill", kill_request, 32'h1);
    chk("irq", irq, 32'h1);
    for (int a = 0; a < 3; a++) apb(1'b1, REG_ISW + 8'(4 * a), 32'h1);
    chk("irq clr", irq, 32'h0);
    feed(1'b1, 32'd2000, 32'd1744);
    tick();
    rdchk("at limit", REG_ISW, 32'h0);
    feed(1'b0, 32'd2000, 32'd2065);
    tick();
    rdchk("settling", REG_STATE, 32'h2);
    chk("settle torque", holding_torque, 32'h0);
    tick();
    chk("tick gap", gap, SERVO_CYCLES);
    chk("hold torque", holding_torque, 32'h1);
    rdchk("no move flag", REG_ISW, 32'h0);
    tick();
    rdchk("hold flag", REG_ISW, 32'h2);
    rdchk("hold poll", REG_PSW, 32'h2);
    apb(1'b1, REG_ISW, 32'h2);
    apb(1'b1, REG_CTRL, 32'h1);
    rdchk("drag enable", REG_CTRL, 32'h1);
    feed(1'b0, 32'd2000, 32'd2300);
    tick();
    chk("drag hold", control_target, exp_tgt(1'b1, 32'd2300, 32'd2000, 32'h40));
    rdchk("target reg", REG_TARGET, exp_tgt(1'b1, 32'd2300, 32'd2000, 32'h40));
    rdchk("drag flag", REG_ISW, 32'h2);
    chk("drag kill", kill_request, 32'h1);
    feed(1'b1, 32'd5000, 32'd4400);
    tick();
    chk("drag move", control_target, exp_tgt(1'b1, 32'd4400, 32'd5000, 32'h100));
    repeat (3) begin
      t = $urandom;
      rd = t + 32'($urandom_range(0, 1023)) - 32'd512;
      feed(1'b1, t, rd);
      tick();
      chk("rand drag", control_target, exp_tgt(1'b1, rd, t, 32'h100));
    end
    end_of_test();
  end
endmodule
